// >>> hdl/acsrd_top.sv
// Master clock select, modulator divider and output rate timing
// What this block does
// - After reset with clock pin grounded, internal oscillator is master clock.
// - Edges on the clock pin switch to external clock at any time.
// - External clock stays selected until device reset or power cycle.
// - Modulator divide is 128, 32, 16 or 8 by rate group.
// - Modulator spans 32 kHz to 512 kHz at nominal master clock.
// - Filter response follows the programmed output rate setting.
// - First result after start or rate change is fully settled.
// - Rates scale with master clock, internal oscillator included.
// - Exact rates at 4.096 MHz follow the decimation counts.
`timescale 1ns/1ps
`default_nettype none
module acsrd_top
    import acsrd_pkg::*;
(
    input  wire logic                    clock_i,
    input  wire logic                    rstn_i,
    input  wire logic                    int_osc_tick_i,
    input  wire logic                    clock_pin_i,
    input  wire acsrd_pkg::acsrd_ctrl_t  ctrl_i,
    output logic                         int_osc_enable_o,
    output acsrd_pkg::acsrd_stat_t       stat_o,
    output logic      [3:0]              active_rate_o
);
    import acsrd_pkg::*;

    typedef struct packed {
        acsrd_src_t  src;
        logic        pin_prev;
        logic [1:0]  edge_cnt;
        logic [7:0]  div_cnt;
        logic [12:0] dec_cnt;
        logic [3:0]  rate;
        logic        running;
        logic        osc_en;
        acsrd_stat_t stat;
    } acsrd_state_t;

    acsrd_state_t state_q;
    acsrd_state_t state_d;
    logic [7:0]   div_ratio;
    logic [12:0]  dec_count;
    logic         master_tick;
    logic         pin_rise;
    logic         restart_req;

    // Rate setting decoded to divider and filter length
    acsrd_rate_table u_table (
        .output_rate_setting_i (ctrl_i.output_rate_setting),
        .div_ratio_o           (div_ratio),
        .dec_count_o           (dec_count)
    );

    assign pin_rise    = clock_pin_i & ~state_q.pin_prev;
    assign master_tick = (state_q.src == ACSRD_SRC_EXT) ? pin_rise
                                                        : int_osc_tick_i;

    assign restart_req = ctrl_i.start
                       | (ctrl_i.output_rate_setting != state_q.rate);

    // Counter at its last value
    function automatic logic at_last(input logic [12:0] cnt,
                                     input logic [12:0] len);
        return cnt == len - 13'h0001;
    endfunction

    always_comb begin
        state_d = state_q;
        state_d.pin_prev = clock_pin_i;
        state_d.stat.mod_tick = 1'b0;
        state_d.stat.data_ready = 1'b0;
        if (pin_rise && state_q.src == ACSRD_SRC_INT) begin
            if (at_last(13'(state_q.edge_cnt), 13'(EDGE_ACCEPT))) begin
                state_d.src = ACSRD_SRC_EXT;
                state_d.osc_en = 1'b0;
            end else begin
                state_d.edge_cnt = state_q.edge_cnt + 2'h1;
            end
        end
        if (state_q.src == ACSRD_SRC_EXT) begin
            state_d.osc_en = 1'b0;
        end
        state_d.stat.ext_clock_active = (state_d.src == ACSRD_SRC_EXT);
        if (restart_req) begin
            state_d.rate = ctrl_i.output_rate_setting;
            state_d.running = 1'b1;
            state_d.div_cnt = 8'h00;
            state_d.dec_cnt = 13'h0000;
            state_d.stat.filter_settled = 1'b0;
        end else if (master_tick && state_q.running) begin
            if (at_last(13'(state_q.div_cnt), 13'(div_ratio))) begin
                state_d.div_cnt = 8'h00;
                state_d.stat.mod_tick = 1'b1;
                if (at_last(state_q.dec_cnt, dec_count)) begin
                    state_d.dec_cnt = 13'h0000;
                    state_d.stat.data_ready = 1'b1;
                    state_d.stat.filter_settled = 1'b1;
                end else begin
                    state_d.dec_cnt = state_q.dec_cnt + 13'h0001;
                end
            end else begin
                state_d.div_cnt = state_q.div_cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= '{src: ACSRD_SRC_INT, pin_prev: 1'b0, edge_cnt: 2'h0,
                         div_cnt: 8'h00, dec_cnt: 13'h0000,
                         rate: RATE_RESET, running: 1'b0, osc_en: 1'b1,
                         stat: '0};
        end else begin
            state_q <= state_d;
        end
    end

    assign int_osc_enable_o = state_q.osc_en;
    assign stat_o           = state_q.stat;
    assign active_rate_o    = state_q.rate;

    // Last master tick of a modulator period
    sequence div_last_s;
        master_tick && state_q.running && !restart_req &&
        at_last(13'(state_q.div_cnt), 13'(div_ratio));
    endsequence

    // Last modulator period of an output period
    sequence dec_last_s;
        at_last(state_q.dec_cnt, dec_count);
    endsequence

    ext_sticky_a: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        state_q.src == ACSRD_SRC_EXT |=> state_q.src == ACSRD_SRC_EXT)
        else $error("external clock selection was lost");
    osc_off_a: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        state_q.src == ACSRD_SRC_EXT |-> !int_osc_enable_o)
        else $error("oscillator enabled on external clock");
    pin_switch_a: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        (pin_rise && state_q.edge_cnt == 2'h1) |=>
        state_q.src == ACSRD_SRC_EXT)
        else $error("clock pin edges did not select external clock");
    quiet_pin_a: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        (state_q.src == ACSRD_SRC_INT && !pin_rise) |=>
        state_q.src == ACSRD_SRC_INT)
        else $error("switched source without pin edge");
    osc_on_int_a: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        state_q.src == ACSRD_SRC_INT |-> int_osc_enable_o)
        else $error("oscillator disabled on internal clock");
    ext_flag_a: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        stat_o.ext_clock_active == (state_q.src == ACSRD_SRC_EXT))
        else $error("external clock flag disagrees with source");
    ready_pulse_a: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        stat_o.data_ready |=> !stat_o.data_ready)
        else $error("result strobe longer than one cycle");
    ready_tick_a: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        stat_o.data_ready |-> stat_o.mod_tick)
        else $error("result without modulator tick");
    result_wrap_a: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        div_last_s ##0 dec_last_s |=>
        stat_o.data_ready && stat_o.filter_settled)
        else $error("result missing at end of output period");
    ready_settled_a: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        stat_o.data_ready |-> stat_o.filter_settled)
        else $error("result delivered before settling");
    start_restart_a: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        ctrl_i.start |=> !stat_o.filter_settled && !stat_o.data_ready &&
        state_q.div_cnt == 8'h00 && state_q.dec_cnt == 13'h0000)
        else $error("start did not restart filter");
    div_range_a: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        state_q.div_cnt < DIV_GROUP_SLOW)
        else $error("modulator divider out of range");
    mod_wrap_a: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        div_last_s |=> stat_o.mod_tick)
        else $error("modulator tick missing at divider wrap");
    tick_source_a: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        stat_o.mod_tick |-> $past(master_tick))
        else $error("modulator tick without master clock tick");
    dec_range_a: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        state_q.dec_cnt < DEC_5)
        else $error("decimation counter out of range");
    rate_restart_a: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        ctrl_i.output_rate_setting != state_q.rate |=>
        !stat_o.filter_settled && state_q.dec_cnt == 13'h0000)
        else $error("rate change did not restart filter");
    rate_follow_a: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        ctrl_i.output_rate_setting != active_rate_o |=>
        active_rate_o == $past(ctrl_i.output_rate_setting))
        else $error("active rate did not follow setting");
endmodule
`default_nettype wire

// >>> include/acsrd_pkg.sv
// Constants and types for the converter clock select and rate divider
`default_nettype none
package acsrd_pkg;

    // Nominal master clock and modulator divide ratios per rate group
    localparam int unsigned MASTER_CLOCK_HZ = 4096000;
    localparam logic [7:0]  DIV_GROUP_SLOW  = 8'h80;
    localparam logic [7:0]  DIV_GROUP_MID   = 8'h20;
    localparam logic [7:0]  DIV_GROUP_FAST  = 8'h10;
    localparam logic [7:0]  DIV_GROUP_TOP   = 8'h08;

    // Modulator clocks per output sample, one per rate setting
    // Each entry is modulator cycles per output sample
    localparam logic [12:0] DEC_5    = 13'h18E9;
    localparam logic [12:0] DEC_10   = 13'h0C74;
    localparam logic [12:0] DEC_20   = 13'h063A;
    localparam logic [12:0] DEC_40   = 13'h0C74;
    localparam logic [12:0] DEC_80   = 13'h063A;
    localparam logic [12:0] DEC_160  = 13'h031D;
    localparam logic [12:0] DEC_320  = 13'h031C;
    localparam logic [12:0] DEC_640  = 13'h018E;
    localparam logic [12:0] DEC_1000 = 13'h0100;
    localparam logic [12:0] DEC_2000 = 13'h0100;

    // Clock pin edges seen before the external clock is accepted
    localparam logic [1:0]  EDGE_ACCEPT = 2'h2;

    // Reset values
    localparam logic [3:0]  RATE_RESET  = 4'h2;

    typedef enum logic [1:0] {
        ACSRD_SRC_INT,
        ACSRD_SRC_EXT
    } acsrd_src_t;

    typedef struct packed {
        logic [3:0] output_rate_setting;
        logic       start;
    } acsrd_ctrl_t;

    typedef struct packed {
        logic       data_ready;
        logic       filter_settled;
        logic       ext_clock_active;
        logic       mod_tick;
    } acsrd_stat_t;

endpackage
`default_nettype wire

// >>> hdl/acsrd_rate_table.sv
// Rate setting decode into divide ratio and decimation count
`timescale 1ns/1ps
`default_nettype none
module acsrd_rate_table
    import acsrd_pkg::*;
(
    input  wire logic [3:0]  output_rate_setting_i,
    output logic      [7:0]  div_ratio_o,
    output logic      [12:0] dec_count_o
);
    import acsrd_pkg::*;

    always_comb begin
        case (output_rate_setting_i)
            4'h0, 4'h1, 4'h2: div_ratio_o = DIV_GROUP_SLOW;
            4'h3, 4'h4, 4'h5: div_ratio_o = DIV_GROUP_MID;
            4'h6, 4'h7, 4'h8: div_ratio_o = DIV_GROUP_FAST;
            default:          div_ratio_o = DIV_GROUP_TOP;
        endcase
        case (output_rate_setting_i)
            4'h0:    dec_count_o = DEC_5;
            4'h1:    dec_count_o = DEC_10;
            4'h2:    dec_count_o = DEC_20;
            4'h3:    dec_count_o = DEC_40;
            4'h4:    dec_count_o = DEC_80;
            4'h5:    dec_count_o = DEC_160;
            4'h6:    dec_count_o = DEC_320;
            4'h7:    dec_count_o = DEC_640;
            4'h8:    dec_count_o = DEC_1000;
            default: dec_count_o = DEC_2000;
        endcase
    end
endmodule
`default_nettype wire

// >>> tb/acsrd_clk_source.sv
// Clock pin partner: external clock source or grounded pin
`timescale 1ns/1ps
`default_nettype none
module acsrd_clk_source (
    input  wire logic clock_i,
    input  wire logic rstn_i,
    input  wire logic run_i,
    output logic      pin_o
);
    logic [1:0] cnt_q;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
        end
    end
    assign pin_o = run_i & cnt_q[1];
endmodule
`default_nettype wire

// >>> tb/acsrd_top_test.sv
// Self-checking bench for clock select and rate divider
`timescale 1ns/1ps
`default_nettype none
module acsrd_top_test;
    import acsrd_pkg::*;
    logic        clock_i;
    logic        rstn_i;
    logic        tick;
    logic        slow_osc;
    logic        run_ext;
    logic        pin;
    logic        osc_en;
    logic [3:0]  rate;
    acsrd_ctrl_t ctrl;
    acsrd_stat_t stat;
    int          mismatches;
    int          n_tests;
    int          n;

    acsrd_clk_source src_u (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .run_i   (run_ext),
        .pin_o   (pin)
    );
    acsrd_top dut_u (
        .clock_i          (clock_i),
        .rstn_i           (rstn_i),
        .int_osc_tick_i   (tick),
        .clock_pin_i      (pin),
        .ctrl_i           (ctrl),
        .int_osc_enable_o (osc_en),
        .stat_o           (stat),
        .active_rate_o    (rate)
    );

    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    // Internal oscillator ticks every cycle, or every second one
    always @(negedge clock_i) begin
        tick <= !slow_osc || !tick;
    end

    task automatic report_and_stop();
        if (mismatches == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Cycles between two pulses of mod_tick (sel 0) or data_ready
    task automatic measure(input int sel, output int cnt);
        int k;
        cnt = 0;
        for (k = 0; k < 20000; k++) begin
            @(negedge clock_i);
            if ((sel ? stat.data_ready : stat.mod_tick) === 1'b1) begin
                if (cnt > 0) return;
                cnt = 1;
            end else if (cnt > 0) cnt++;
        end
        mismatches++;
        report_and_stop();
    endtask

    task automatic set_rate(input logic [3:0] code);
        @(negedge clock_i);
        ctrl.output_rate_setting = code;
        ctrl.start = 1'b1;
        @(negedge clock_i);
        ctrl.start = 1'b0;
        check(16'(rate), 16'(code));
    endtask

    task automatic do_reset();
        rstn_i = 1'b0;
        repeat (5) @(negedge clock_i);
        check(16'({osc_en, stat.ext_clock_active, rate}), 16'h0022);
        rstn_i = 1'b1;
    endtask

    task automatic scen_groups();
        logic [3:0] codes [4] = '{4'h0, 4'h3, 4'h6, 4'h9};
        int         divs [4] = '{128, 32, 16, 8};
        for (int i = 0; i < 4; i++) begin
            set_rate(codes[i]);
            measure(0, n);
            check(n[15:0], divs[i][15:0]);
        end
        slow_osc = 1'b1;
        set_rate(4'h9);
        measure(0, n);
        check(n[15:0], 16'h0010);
        slow_osc = 1'b0;
    endtask

    task automatic scen_results();
        set_rate(4'h2);
        measure(0, n);
        check(n[15:0], 16'h0080);
        set_rate(4'h9);
        check(16'(stat.filter_settled), 16'h0000);
        measure(1, n);
        check(n[15:0], 16'h0800);
        check(16'(stat.filter_settled), 16'h0001);
        set_rate(4'h9);
        check(16'(stat.filter_settled), 16'h0000);
        set_rate(4'h8);
        measure(1, n);
        check(n[15:0], 16'h1000);
    endtask

    task automatic scen_ext();
        run_ext = 1'b1;
        repeat (20) @(negedge clock_i);
        check(16'({osc_en, stat.ext_clock_active}), 16'h0001);
        set_rate(4'h9);
        measure(0, n);
        check(n[15:0], 16'h0020);
        run_ext = 1'b0;
        repeat (20) @(negedge clock_i);
        check(16'(stat.ext_clock_active), 16'h0001);
        do_reset();
        repeat (2) @(negedge clock_i);
        check(16'({osc_en, stat.ext_clock_active}), 16'h0002);
    endtask

    initial begin
        mismatches = 0;
        n_tests = 0;
        slow_osc = 1'b0;
        run_ext = 1'b0;
        ctrl = '0;
        do_reset();
        scen_groups();
        scen_results();
        scen_ext();
        report_and_stop();
    end
endmodule
`default_nettype wire
